// ===== dmcbi_pkg.sv
/*
 * Shared constants for the disk and memory-copy bus interface.
 * Assumes a single 200 MHz clock domain and a synchronous active-low reset.
 */
package dmcbi_pkg;
  // Decoder base nibble, the jumper default.
  localparam logic [3:0] BASE_NIBBLE = 4'hE;
  // Sub-unit codes on address bits 3:2.
  localparam logic [1:0] UNIT_CMD = 2'h0;
  localparam logic [1:0] UNIT_PIO = 2'h1;
  localparam logic [1:0] UNIT_DMA = 2'h2;
  localparam logic [1:0] UNIT_CTC = 2'h3;
  // Offsets inside the window.
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_EXT = 4'h1;
  localparam logic [3:0] OFS_DMA = 4'h8;
  localparam logic [3:0] OFS_CTC_LAST = 4'hE;
  // DMA programming sequence positions at the DMA port.
  localparam logic [2:0] PRG_MODE = 3'h0;
  localparam logic [2:0] PRG_LAST = 3'h6;
  // DMA mode byte values.
  localparam logic [7:0] MODE_DISK = 8'h01;
  localparam logic [7:0] MODE_COPY = 8'h02;
  // Sector format.
  localparam logic [7:0] SYNC_BYTE = 8'h01;
  localparam logic [9:0] PREAMBLE_LEN = 10'h00A;
  localparam logic [9:0] POSTAMBLE_LEN = 10'h00A;
  localparam logic [9:0] ID_LEN = 10'h004;
  localparam logic [9:0] DATA_LEN = 10'h200;
  localparam logic [9:0] WRITE_BLOCK = 10'h205;
  localparam logic [9:0] READ_HDR = 10'h004;
  localparam logic [9:0] READ_FULL = 10'h204;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // Reset values.
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // FIFO shape.
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;
  // Formatter states.
  typedef enum logic [2:0] {
    FMT_IDLE = 3'b000,
    FMT_PRE = 3'b001,
    FMT_SYNC = 3'b010,
    FMT_ID = 3'b011,
    FMT_HCRC = 3'b100,
    FMT_DATA = 3'b101,
    FMT_DCRC = 3'b110,
    FMT_POST = 3'b111
  } dmcbi_fmt_e;
  // Copy engine states.
  typedef enum logic [1:0] {
    CPY_IDLE = 2'b00,
    CPY_READ = 2'b01,
    CPY_WRITE = 2'b10
  } dmcbi_cpy_e;
endpackage : dmcbi_pkg

// ===== dmcbi_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module dmcbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  // Full when pointers differ only in the wrap bit.
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  // Storage writes need no reset.
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  // Pointer update.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : dmcbi_fifo

// ===== dmcbi_top.sv
/*
 * Host-bus side of a disk and memory-copy interface board: window decode,
 * extended-address latch, DMA engine for disk and copy transfers, and the
 * sector formatter with its CRC. Assumes host strobes synchronous to clk.
 */
// Overview of operation
// - Disk DMA advances only with pace ready.
// - Write preamble, header, data, CRC, postamble.
// - Header is sync, IDs, CRC, zero.
// - IDs are head, cylinder two, sector.
// - Pace ready drops during generated bytes.
// - Header CRC over IDs; data CRC over data.
// - Read stores 4 or 516 bytes.
// - Only the sync byte is skipped on read.
// - Copy uses source, destination, count; ignores ready.
// - Copy requests bus, waits for grant.
// - Hold bus until count exhausted.
// - Extended-address write drives A16-A23.
// - Decode window, unit bits, mode bits.
// - Offsets 0,1 select command path, latch.
// - Offsets 4-7 select parallel controller.
// - Offset 8 selects DMA.
// - Offsets C-E select counter channels.
// - DMA address drives bus while master.
// - Path select high during disk transfer.
// - Control buffers follow bus-master flag.
// - Write block is 517 bytes.
// - Pace ready two register stages.
`timescale 1ns/1ps
module dmcbi_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Host I/O cycle.
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] host_data_out_lines,
  // Decoded selects.
  output logic cmd_status_select_n,
  output logic parallel_io_select_n,
  output logic dma_select_n,
  output logic counter_timer_select_n,
  output logic [1:0] unit_mode,
  // Bus mastership.
  output logic bus_request_n,
  input wire logic bus_grant_n,
  output logic bus_master,
  output logic ctrl_buf_drive,
  // Memory bus while master.
  output logic [15:0] mem_addr,
  output logic [7:0] ext_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Disk transfer control.
  input wire logic pace_start,
  input wire logic disk_read,
  output logic transfer_path_select,
  output logic pace_ready,
  output logic pace_ready_sync,
  output logic busy,
  output logic crc_error,
  // Serial formatter byte stream.
  output logic disk_valid,
  output logic [7:0] disk_byte,
  input wire logic disk_take,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte
);
  // Decode state.
  logic win_hit;
  logic io_ext;
  logic io_dma;
  logic [7:0] ext_q;
  // DMA programming registers.
  logic [2:0] prg_q;
  logic [7:0] mode_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [9:0] cnt_q;
  logic copy_arm_q;
  logic disk_arm_q;
  dmcbi_pkg::dmcbi_cpy_e cpy_q;
  logic [7:0] cpy_data_q;
  // Formatter state.
  dmcbi_pkg::dmcbi_fmt_e fmt_q;
  logic [9:0] fcnt_q;
  logic [15:0] crc_q;
  logic crc_feed;
  logic [7:0] crc_byte;
  logic [15:0] crc_next;
  logic [1:0] rd_skip_q;
  logic rd_hdr_q;
  logic p1_q;
  logic p2_q;
  // FIFO between memory fetch and formatter.
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;
  logic req_q;

  assign win_hit = io_addr[7:4] == dmcbi_pkg::BASE_NIBBLE;
  assign unit_mode = io_addr[1:0];
  assign cmd_status_select_n = !(win_hit && io_addr[3:2] == dmcbi_pkg::UNIT_CMD);
  assign parallel_io_select_n = !(win_hit && io_addr[3:2] == dmcbi_pkg::UNIT_PIO);
  // DMA only at its one offset.
  assign dma_select_n = !(win_hit && io_addr[3:0] == dmcbi_pkg::OFS_DMA);
  assign counter_timer_select_n = !(win_hit && io_addr[3:2] == dmcbi_pkg::UNIT_CTC
                                    && io_addr[3:0] <= dmcbi_pkg::OFS_CTC_LAST);
  assign io_ext = io_wr && win_hit && io_addr[3:0] == dmcbi_pkg::OFS_EXT;
  assign io_dma = io_wr && !dma_select_n;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_q <= dmcbi_pkg::EXT_RESET;
    end else if (io_ext) begin
      ext_q <= host_data_out_lines;
    end
  end
  assign ext_addr = ext_q;

  // Programming sequence: mode, src lo/hi, dst lo/hi, count lo/hi.
  // start address and count held for disk.
  // source, destination and count for copy.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prg_q <= dmcbi_pkg::PRG_MODE;
      mode_q <= 8'h00;
      copy_arm_q <= 1'b0;
      disk_arm_q <= 1'b0;
    end else begin
      copy_arm_q <= 1'b0;
      if (io_dma) begin
        case (prg_q)
          3'h0: mode_q <= host_data_out_lines;
          default: ;
        endcase
        if (prg_q == dmcbi_pkg::PRG_LAST) begin
          prg_q <= dmcbi_pkg::PRG_MODE;
          copy_arm_q <= mode_q == dmcbi_pkg::MODE_COPY;
          disk_arm_q <= mode_q == dmcbi_pkg::MODE_DISK;
        end else begin
          prg_q <= prg_q + 3'h1;
        end
      end else if (fmt_q != dmcbi_pkg::FMT_IDLE) begin
        disk_arm_q <= 1'b0;
      end
    end
  end

  // Address and count registers, advanced by the engines.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_q <= dmcbi_pkg::ADDR_RESET;
      dst_q <= dmcbi_pkg::ADDR_RESET;
      cnt_q <= '0;
    end else if (io_dma) begin
      case (prg_q)
        3'h1: src_q[7:0] <= host_data_out_lines;
        3'h2: src_q[15:8] <= host_data_out_lines;
        3'h3: dst_q[7:0] <= host_data_out_lines;
        3'h4: dst_q[15:8] <= host_data_out_lines;
        3'h5: cnt_q[7:0] <= host_data_out_lines;
        3'h6: cnt_q[9:8] <= host_data_out_lines[1:0];
        default: ;
      endcase
    end else if (cpy_q == dmcbi_pkg::CPY_WRITE) begin
      src_q <= src_q + 16'h0001;
      dst_q <= dst_q + 16'h0001;
      cnt_q <= cnt_q - 10'h001;
    end else if ((f_in_valid && f_in_ready) || (disk_read && rd_valid && mem_wr)) begin
      // Disk fetches and stores both walk the source register, in the fetch cycle itself.
      src_q <= src_q + 16'h0001;
      cnt_q <= cnt_q - 10'h001;
    end
  end

  // copy waits for grant before moving data.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpy_q <= dmcbi_pkg::CPY_IDLE;
      cpy_data_q <= 8'h00;
    end else begin
      case (cpy_q)
        dmcbi_pkg::CPY_IDLE: if (req_q && !bus_grant_n && mode_q == dmcbi_pkg::MODE_COPY
                                 && cnt_q != '0) begin
          cpy_q <= dmcbi_pkg::CPY_READ;
        end
        dmcbi_pkg::CPY_READ: begin
          cpy_data_q <= mem_rdata;
          cpy_q <= dmcbi_pkg::CPY_WRITE;
        end
        dmcbi_pkg::CPY_WRITE: begin
          cpy_q <= cnt_q == 10'h001 ? dmcbi_pkg::CPY_IDLE : dmcbi_pkg::CPY_READ;
        end
        default: cpy_q <= dmcbi_pkg::CPY_IDLE;
      endcase
    end
  end

  // Bus request: copy raises it at once; disk raises it on pace ready.
  // released when the count runs out.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_q <= 1'b0;
    end else if (copy_arm_q) begin
      req_q <= 1'b1;
    end else if (cnt_q == '0 && cpy_q == dmcbi_pkg::CPY_IDLE) begin
      req_q <= 1'b0;
    end else if (pace_ready && fmt_q != dmcbi_pkg::FMT_IDLE) begin
      req_q <= 1'b1;
    end
  end
  assign bus_request_n = !req_q;
  // master flag from request and grant.
  assign bus_master = req_q && !bus_grant_n;
  assign ctrl_buf_drive = bus_master;
  assign busy = req_q || fmt_q != dmcbi_pkg::FMT_IDLE;

  // DMA address on the bus while master.
  assign mem_addr = !bus_master ? dmcbi_pkg::ADDR_RESET
                  : (cpy_q == dmcbi_pkg::CPY_WRITE ? dst_q : src_q);
  assign mem_rd = bus_master && (cpy_q == dmcbi_pkg::CPY_READ || (f_in_valid && !disk_read));
  // every read byte after the skipped sync byte is stored while the board is bus master.
  assign mem_wr = bus_master && (cpy_q == dmcbi_pkg::CPY_WRITE
                  || (disk_read && rd_valid && rd_skip_q == 2'h0 && !rd_hdr_q));
  assign mem_wdata = cpy_q == dmcbi_pkg::CPY_WRITE ? cpy_data_q : rd_byte;

  // fetch only while pace ready and counting.
  // copy mode never looks at pace ready.
  assign f_in_valid = bus_master && pace_ready && !disk_read && cnt_q != '0
                      && mode_q == dmcbi_pkg::MODE_DISK;

  // Buffer stalls memory fetch when the formatter lags.
  dmcbi_fifo #(
    .WIDTH(dmcbi_pkg::FIFO_WIDTH),
    .DEPTH(dmcbi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(mem_rdata),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // pace ready only where memory bytes are needed.
  // write block of 517 bytes programmed.
  assign pace_ready = (fmt_q == dmcbi_pkg::FMT_SYNC || fmt_q == dmcbi_pkg::FMT_ID
                       || fmt_q == dmcbi_pkg::FMT_DATA) && f_in_ready;
  // two register stages of pace ready.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
    end else begin
      p1_q <= pace_ready;
      p2_q <= p1_q;
    end
  end
  assign pace_ready_sync = p2_q;
  // path select high during disk transfer.
  assign transfer_path_select = fmt_q != dmcbi_pkg::FMT_IDLE;

  // sync, IDs, CRC then trailing zero.
  always_comb begin
    disk_valid = 1'b0;
    disk_byte = 8'h00;
    f_out_ready = 1'b0;
    case (fmt_q)
      dmcbi_pkg::FMT_PRE, dmcbi_pkg::FMT_POST: disk_valid = !disk_read;
      dmcbi_pkg::FMT_SYNC, dmcbi_pkg::FMT_ID, dmcbi_pkg::FMT_DATA: begin
        disk_valid = f_out_valid && !disk_read;
        disk_byte = f_out_data;
        f_out_ready = disk_take && !disk_read;
      end
      dmcbi_pkg::FMT_HCRC, dmcbi_pkg::FMT_DCRC: begin
        disk_valid = !disk_read;
        // Two CRC bytes high first, then the trailing zero in the header.
        disk_byte = fcnt_q == 10'h0 ? crc_q[15:8] : (fcnt_q == 10'h1 ? crc_q[7:0] : 8'h00);
      end
      default: ;
    endcase
  end

  // CRC fed by IDs or data bytes only.
  assign crc_feed = disk_read ? (rd_valid && mem_wr)
                  : (disk_valid && disk_take
                     && (fmt_q == dmcbi_pkg::FMT_ID || fmt_q == dmcbi_pkg::FMT_DATA));
  assign crc_byte = disk_read ? rd_byte : f_out_data;
  always_comb begin
    crc_next = crc_q;
    for (int i = 7; i >= 0; i--) begin
      crc_next = {crc_next[14:0], 1'b0}
               ^ ((crc_next[15] ^ crc_byte[i]) ? dmcbi_pkg::CRC_POLY : 16'h0000);
    end
  end

  // formatter state walk with byte counts.
  // four ID bytes head, cylinder, sector.
  // read stores IDs or IDs plus data.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fmt_q <= dmcbi_pkg::FMT_IDLE;
      fcnt_q <= '0;
      crc_q <= dmcbi_pkg::CRC_INIT;
      crc_error <= 1'b0;
      rd_skip_q <= 2'h0;
      rd_hdr_q <= 1'b0;
    end else begin
      if (crc_feed) begin
        crc_q <= crc_next;
      end
      case (fmt_q)
        dmcbi_pkg::FMT_IDLE: begin
          fcnt_q <= '0;
          crc_q <= dmcbi_pkg::CRC_INIT;
          if (pace_start && disk_arm_q) begin
            fmt_q <= disk_read ? dmcbi_pkg::FMT_ID : dmcbi_pkg::FMT_PRE;
            crc_error <= 1'b0;
            // Read stream skips the sync byte before storing.
            rd_skip_q <= disk_read ? 2'h1 : 2'h0;
            rd_hdr_q <= 1'b0;
          end
        end
        dmcbi_pkg::FMT_PRE: if (disk_take) begin
          fcnt_q <= fcnt_q + 10'h1;
          if (fcnt_q == dmcbi_pkg::PREAMBLE_LEN - 10'h1) begin
            fcnt_q <= '0;
            fmt_q <= dmcbi_pkg::FMT_SYNC;
          end
        end
        dmcbi_pkg::FMT_SYNC: if (f_out_valid && disk_take) begin
          fmt_q <= dmcbi_pkg::FMT_ID;
        end
        dmcbi_pkg::FMT_ID: begin
          if (disk_read) begin
            if (rd_valid) begin
              if (rd_skip_q != 2'h0) begin
                rd_skip_q <= rd_skip_q - 2'h1;
              end else if (cnt_q == 10'h001) begin
                fmt_q <= dmcbi_pkg::FMT_IDLE;
              end
            end
          end else if (f_out_valid && disk_take) begin
            fcnt_q <= fcnt_q + 10'h1;
            if (fcnt_q == dmcbi_pkg::ID_LEN - 10'h1) begin
              fcnt_q <= '0;
              fmt_q <= dmcbi_pkg::FMT_HCRC;
            end
          end
        end
        dmcbi_pkg::FMT_HCRC, dmcbi_pkg::FMT_DCRC: if (disk_take) begin
          fcnt_q <= fcnt_q + 10'h1;
          if (fmt_q == dmcbi_pkg::FMT_HCRC && fcnt_q == 10'h2) begin
            fcnt_q <= '0;
            crc_q <= dmcbi_pkg::CRC_INIT;
            fmt_q <= dmcbi_pkg::FMT_DATA;
          end else if (fmt_q == dmcbi_pkg::FMT_DCRC && fcnt_q == 10'h1) begin
            fcnt_q <= '0;
            fmt_q <= dmcbi_pkg::FMT_POST;
          end
        end
        dmcbi_pkg::FMT_DATA: if (f_out_valid && disk_take) begin
          fcnt_q <= fcnt_q + 10'h1;
          if (fcnt_q == dmcbi_pkg::DATA_LEN - 10'h1) begin
            fcnt_q <= '0;
            fmt_q <= dmcbi_pkg::FMT_DCRC;
          end
        end
        dmcbi_pkg::FMT_POST: if (disk_take) begin
          fcnt_q <= fcnt_q + 10'h1;
          if (fcnt_q == dmcbi_pkg::POSTAMBLE_LEN - 10'h1) begin
            fmt_q <= dmcbi_pkg::FMT_IDLE;
          end
        end
        default: fmt_q <= dmcbi_pkg::FMT_IDLE;
      endcase
    end
  end
endmodule : dmcbi_top

// ===== dmcbi_top_checker.sv
/*
 * Concurrent checks on the ports of the disk and memory-copy bus interface.
 * Assumes one clock domain and the synchronous active-low reset of the top.
 */
`timescale 1ns/1ps
module dmcbi_top_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Host I/O cycle.
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] host_data_out_lines,
  // Decoded selects.
  input wire logic cmd_status_select_n,
  input wire logic parallel_io_select_n,
  input wire logic dma_select_n,
  input wire logic counter_timer_select_n,
  input wire logic [1:0] unit_mode,
  // Mastership and memory bus.
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic bus_master,
  input wire logic ctrl_buf_drive,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] ext_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  // Disk transfer control.
  input wire logic pace_ready,
  input wire logic pace_ready_sync,
  input wire logic transfer_path_select,
  input wire logic disk_valid
);
  // Every check samples on the rising edge and rests while reset is held.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sel_cmd_a: assert property (cmd_status_select_n == (io_addr[7:2] != 6'h38))
    else $error("command select wrong");
  sel_pio_a: assert property (parallel_io_select_n == (io_addr[7:2] != 6'h39))
    else $error("parallel select wrong");
  sel_dma_a: assert property (dma_select_n == (io_addr != 8'hE8))
    else $error("dma select wrong");
  sel_ctc_a: assert property (counter_timer_select_n == !(io_addr inside {[8'hEC:8'hEE]}))
    else $error("counter select wrong");
  unit_mode_a: assert property (unit_mode == io_addr[1:0])
    else $error("unit mode wrong");
  ext_latch_a: assert property (io_wr && io_addr == 8'hE1 |=> ext_addr == $past(host_data_out_lines))
    else $error("extended address not latched");
  ext_hold_a: assert property (!(io_wr && io_addr == 8'hE1) |=> $stable(ext_addr))
    else $error("extended address moved");
  master_flag_a: assert property (bus_master == (!bus_request_n && !bus_grant_n) && ctrl_buf_drive == bus_master)
    else $error("master flag wrong");
  strobe_owner_a: assert property ((mem_rd || mem_wr) |-> bus_master)
    else $error("strobe without bus");
  addr_idle_a: assert property (!bus_master |-> mem_addr == 16'h0000)
    else $error("address driven while not master");
  pace_sync_a: assert property ($past(resetn) && $past(resetn, 2) |-> pace_ready_sync == $past(pace_ready, 2))
    else $error("pace sync not two stages");
  path_pace_a: assert property (pace_ready |-> transfer_path_select)
    else $error("pace ready outside disk path");

  // Main scenarios worth seeing at least once.
  copy_cov: cover property (bus_master && mem_wr);
  disk_cov: cover property (disk_valid && transfer_path_select);
  ext_cov: cover property (io_wr && io_addr == 8'hE1);
endmodule : dmcbi_top_checker

bind dmcbi_top dmcbi_top_checker dmcbi_top_checker_inst (.*);

// ===== dmcbi_host_model.sv
/*
 * Host bus partner: CPU grant logic and a small main memory image.
 * Assumes the board's strobes are levels sampled on the rising edge.
 */
`timescale 1ns/1ps
module dmcbi_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Grant latency in cycles, chosen by the bench.
  input wire logic [3:0] grant_delay,
  // Mastership handshake.
  input wire logic bus_request_n,
  output logic bus_grant_n,
  // Memory cycles from the board.
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // Memory image; the bench loads it directly.
  logic [7:0] mem [0:2047];
  logic [3:0] wait_q;
  logic [7:0] last_q;

  always_ff @(posedge clk) begin
    if (!resetn || bus_request_n) begin
      wait_q <= 4'h0;
      bus_grant_n <= 1'b1;
    end else if (wait_q < grant_delay) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      bus_grant_n <= 1'b0;
    end
  end

  // staged block stored; writes land only while the board is granted.
  always @(posedge clk) begin
    if (mem_wr && !bus_grant_n) begin
      mem[mem_addr[10:0]] <= mem_wdata;
    end
    last_q <= !resetn ? 8'h00 : (mem_rd ? mem[mem_addr[10:0]] : last_q);
  end

  // An idle data bus shows the inverse of the last byte, so stale data never matches.
  assign mem_rdata = (mem_rd && !bus_grant_n) ? mem[mem_addr[10:0]] : ~last_q;
endmodule : dmcbi_host_model

// ===== dmcbi_top_tb.sv
/*
 * Self-checking bench: decode table, extended latch, copy, disk write and read.
 * Assumes the host model above and the constants of dmcbi_pkg.
 */
`timescale 1ns/1ps
module dmcbi_top_tb;
  // Design ports, connected by name.
  logic clk, resetn, io_wr, pace_start, disk_read, disk_take, rd_valid;
  logic [7:0] io_addr, host_data_out_lines, ext_addr, mem_wdata, mem_rdata, disk_byte, rd_byte;
  logic cmd_status_select_n, parallel_io_select_n, dma_select_n, counter_timer_select_n;
  logic [1:0] unit_mode;
  logic bus_request_n, bus_grant_n, bus_master, ctrl_buf_drive, mem_rd, mem_wr;
  logic [15:0] mem_addr, c;
  logic transfer_path_select, pace_ready, pace_ready_sync, busy, crc_error, disk_valid;
  logic [3:0] grant_delay;
  logic [7:0] gotq [$];
  logic [7:0] expq [$];
  int checked, n_mismatch, n, nrd, bad;
  // Decode rows: address, then selects cmd/pio/dma/ctc, then unit mode.
  logic [13:0] rows [10] = '{{8'hE0, 4'h7, 2'h0}, {8'hE3, 4'h7, 2'h3}, {8'hE4, 4'hB, 2'h0},
    {8'hE7, 4'hB, 2'h3}, {8'hE8, 4'hD, 2'h0}, {8'hE9, 4'hF, 2'h1}, {8'hEC, 4'hE, 2'h0},
    {8'hEE, 4'hE, 2'h2}, {8'hEF, 4'hF, 2'h3}, {8'hD4, 4'hF, 2'h0}};

  dmcbi_top dmcbi_top_inst (.*);
  dmcbi_host_model dmcbi_host_model_inst (.*);

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Memory contents away from staged blocks.
  function automatic logic [7:0] fill(input int i);
    return 8'(i * 3 + 1);
  endfunction : fill

  // Sector source image: sync, four IDs, then data.
  function automatic logic [7:0] img(input int i);
    return (i == 0) ? dmcbi_pkg::SYNC_BYTE : 8'(i * 7 + 3);
  endfunction : img

  // Bench-side CRC, MSB first.
  function automatic logic [15:0] crc_upd(input logic [15:0] v, input logic [7:0] b);
    v = v ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      v = v[15] ? ({v[14:0], 1'b0} ^ dmcbi_pkg::CRC_POLY) : {v[14:0], 1'b0};
    end
    return v;
  endfunction : crc_upd

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  // One host write; a gap cycle follows so io_wr never toggles twice at one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    host_data_out_lines = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : wr

  task automatic prog(input logic [7:0] m, input logic [15:0] s, input logic [15:0] d,
                      input logic [15:0] k);
    wr(8'hE8, m);
    wr(8'hE8, s[7:0]);
    wr(8'hE8, s[15:8]);
    wr(8'hE8, d[7:0]);
    wr(8'hE8, d[15:8]);
    wr(8'hE8, k[7:0]);
    wr(8'hE8, k[15:8]);
  endtask : prog

  // Bounded wait for the board to finish and let go of the bus.
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (busy === 1'b0 && bus_request_n === 1'b1) return;
    end
    chk(16'(busy), 16'h0000);
  endtask : wait_idle

  task automatic finish_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Watchdog well past the expected run of about a thousand cycles.
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {resetn, io_wr, pace_start, disk_read, disk_take, rd_valid} = 6'h00;
    {io_addr, host_data_out_lines, rd_byte} = 24'h000000;
    grant_delay = 4'h1;
    for (int i = 0; i < 2048; i++) dmcbi_host_model_inst.mem[i] = fill(i);
    repeat (5) @(negedge clk);
    chk(16'(bus_request_n), 16'h0001);
    chk(16'(ext_addr), 16'(dmcbi_pkg::EXT_RESET));
    resetn = 1'b1;
    // Ordinary decode cases from the table.
    foreach (rows[i]) begin
      @(negedge clk);
      io_addr = rows[i][13:6];
      #1;
      chk(16'({cmd_status_select_n, parallel_io_select_n, dma_select_n,
               counter_timer_select_n}), 16'(rows[i][5:2]));
      chk(16'(unit_mode), 16'(rows[i][1:0]));
    end
    // Extended address: latched at once, untouched by the neighbouring port.
    wr(8'hE1, 8'hA5);
    chk(16'(ext_addr), 16'h00A5);
    wr(8'hE0, 8'h3C);
    chk(16'(ext_addr), 16'h00A5);
    // Memory copy of three bytes; pace inputs left low on purpose.
    prog(dmcbi_pkg::MODE_COPY, 16'h0010, 16'h0020, 16'h0003);
    chk(16'(bus_request_n), 16'h0001);
    @(posedge clk);
    #1;
    chk(16'(bus_request_n), 16'h0000);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      chk(16'(dmcbi_host_model_inst.mem[16'h0020 + i]), 16'(fill(i < 3 ? 16 + i : 35)));
    end
    // Sector write with a slow grant and a stalling disk side.
    for (int i = 0; i < 517; i++) dmcbi_host_model_inst.mem[16'h0100 + i] = img(i);
    grant_delay = 4'h3;
    prog(dmcbi_pkg::MODE_DISK, 16'h0100, 16'h0000, 16'(dmcbi_pkg::WRITE_BLOCK));
    @(negedge clk);
    pace_start = 1'b1;
    while ((busy !== 1'b0 || gotq.size() < 542) && n < 20000) begin
      @(negedge clk);
      disk_take = (n % 3 != 0);
      #1;
      if (mem_rd && bus_master) nrd++;
      if (disk_valid && pace_ready && (gotq.size() < 10 || (gotq.size() >= 15 &&
          gotq.size() < 18) || gotq.size() >= 530)) bad++;
      if (disk_valid && disk_take) gotq.push_back(disk_byte);
      n++;
    end
    pace_start = 1'b0;
    repeat (dmcbi_pkg::PREAMBLE_LEN) expq.push_back(8'h00);
    expq.push_back(dmcbi_pkg::SYNC_BYTE);
    c = dmcbi_pkg::CRC_INIT;
    for (int i = 1; i < 5; i++) begin
      expq.push_back(img(i));
      c = crc_upd(c, img(i));
    end
    expq.push_back(c[15:8]);
    expq.push_back(c[7:0]);
    expq.push_back(8'h00);
    c = dmcbi_pkg::CRC_INIT;
    for (int i = 5; i < 517; i++) begin
      expq.push_back(img(i));
      c = crc_upd(c, img(i));
    end
    expq.push_back(c[15:8]);
    expq.push_back(c[7:0]);
    repeat (dmcbi_pkg::POSTAMBLE_LEN) expq.push_back(8'h00);
    chk(16'(gotq.size()), 16'(expq.size()));
    foreach (expq[i]) chk(16'(gotq[i]), 16'(expq[i]));
    chk(16'(nrd), 16'(dmcbi_pkg::WRITE_BLOCK));
    chk(16'(bad), 16'h0000);
    wait_idle();
    // Header read: the sync byte is dropped, four IDs stored, next byte untouched.
    prog(dmcbi_pkg::MODE_DISK, 16'h0500, 16'h0000, 16'(dmcbi_pkg::READ_HDR));
    @(negedge clk);
    disk_read = 1'b1;
    pace_start = 1'b1;
    // The disk stream cannot pause, so it starts only once the board owns the bus.
    for (int i = 0; i < 64 && bus_master !== 1'b1; i++) @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      rd_valid = 1'b1;
      rd_byte = (i == 0) ? dmcbi_pkg::SYNC_BYTE : 8'(8'hC0 + i);
      @(negedge clk);
    end
    rd_valid = 1'b0;
    rd_byte = ~rd_byte;
    wait_idle();
    for (int i = 0; i < 5; i++) begin
      chk(16'(dmcbi_host_model_inst.mem[16'h0500 + i]), 16'(i < 4 ? 8'hC1 + i : fill(1284)));
    end
    @(negedge clk);
    disk_read = 1'b0;
    pace_start = 1'b0;
    finish_test();
  end
endmodule : dmcbi_top_tb
